// *** dv/alcb_cop_model.sv ***
// alcb_cop_model.sv: four coprocessor units giving condition and usable bits.
// assumes the bench sets the requests just after a rising edge.
`timescale 1ns/1ps
module alcb_cop_model (
  input wire mclk, // clock
  input wire [3:0] cond_set, // requested conditions
  input wire [3:0] usable_set, // requested usable flags
  output reg [3:0] cop_condition_input, // condition bits
  output reg [3:0] cop_usable // usable flags
);
  // registered so each bit holds a full cycle around the core's sampling edge
  always @(posedge mclk) begin
    cop_condition_input <= cond_set;
    cop_usable <= usable_set;
  end
endmodule

// *** dv/alcb_exec_properties.sv ***
// alcb_exec_properties.sv: port-level checks of the execute unit.
// assumes binding onto alcb_exec; sees only its ports.
`timescale 1ns/1ps
module alcb_props #(parameter NCOP = 4) (
  input wire mclk, // clock
  input wire resetn, // reset, low
  input wire in_valid, // offer
  input wire [31:0] in_instr, // word
  input wire [31:0] in_pc, // address
  input wire [NCOP-1:0] cop_condition_input, // conditions
  input wire [NCOP-1:0] cop_usable, // usable flags
  input wire wb_valid_q, // write pulse
  input wire [4:0] wb_reg_q, // register
  input wire [31:0] wb_data_q, // value
  input wire redirect_valid_q, // redirect
  input wire [31:0] redirect_pc_q, // target
  input wire slot_nullified_q, // annulled slot
  input wire exc_valid_q, // exception
  input wire [4:0] exc_code_q, // cause
  input wire [31:0] exception_return_pc, // restart
  input wire exc_in_slot_q // fault in slot
);
  reg [1:0] unit_q;
  wire cbr = in_instr[31:28] == 4'h4 && in_instr[25:21] == 5'h08 && in_instr[20:16] < 5'h03;
  // unit of the branch being executed, usable is read one cycle after the offer
  always @(posedge mclk) begin
    unit_q <= in_instr[27:26];
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  property p_slot_exc; exc_in_slot_q |-> exc_valid_q; endproperty
  a_slot_exc: assert property (p_slot_exc) else $error("slot flag without exception");
  property p_epc_hold; !exc_valid_q |-> $stable(exception_return_pc); endproperty
  a_epc_hold: assert property (p_epc_hold) else $error("restart address moved");
  property p_zero_reg; wb_valid_q |-> wb_reg_q != 5'h00; endproperty
  a_zero_reg: assert property (p_zero_reg) else $error("write to register zero");
  property p_null_quiet; slot_nullified_q |-> !wb_valid_q && !exc_valid_q; endproperty
  a_null_quiet: assert property (p_null_quiet) else $error("annulled slot had effect");
  property p_ovf_no_wb; exc_valid_q && exc_code_q == 5'h0c |-> !wb_valid_q; endproperty
  a_ovf_no_wb: assert property (p_ovf_no_wb) else $error("overflow wrote a register");
  property p_nt_reg;
    in_valid && in_instr[31:26] == 6'h00 && in_instr[5:0] == 6'h21 |->
      ##2 !(exc_valid_q && exc_code_q == 5'h0c && !exc_in_slot_q);
  endproperty
  a_nt_reg: assert property (p_nt_reg) else $error("unsigned add trapped");
  property p_imm_bitwise_conj;
    in_valid && in_instr[31:26] == 6'h0c && in_instr[20:16] != 5'h00 ##1 !exc_valid_q |->
      ##1 (slot_nullified_q || (wb_valid_q && wb_reg_q == $past(in_instr[20:16], 2) && wb_data_q[31:16] == 16'h0000));
  endproperty
  a_imm_bitwise_conj: assert property (p_imm_bitwise_conj) else $error("immediate and result wrong");
  property p_unusable;
    in_valid && cbr ##1 !exc_valid_q && !cop_usable[unit_q] |->
      ##1 exc_valid_q && exc_code_q == 5'h0b && !exc_in_slot_q;
  endproperty
  a_unusable: assert property (p_unusable) else $error("unusable unit not trapped");
endmodule
bind alcb_exec alcb_props #(.NCOP(NCOP)) alcb_props_inst (.mclk(mclk), .resetn(resetn),
  .in_valid(in_valid), .in_instr(in_instr), .in_pc(in_pc), .cop_condition_input(cop_condition_input),
  .cop_usable(cop_usable), .wb_valid_q(wb_valid_q), .wb_reg_q(wb_reg_q), .wb_data_q(wb_data_q),
  .redirect_valid_q(redirect_valid_q), .redirect_pc_q(redirect_pc_q), .slot_nullified_q(slot_nullified_q),
  .exc_valid_q(exc_valid_q), .exc_code_q(exc_code_q), .exception_return_pc(exception_return_pc),
  .exc_in_slot_q(exc_in_slot_q));

// *** dv/tb_add_logic_cop_branch_exec.sv ***
// tb_add_logic_cop_branch_exec.sv: self-checking bench of the execute unit.
// assumes alcb_exec, the coprocessor model and the bound checker.
`timescale 1ns/1ps
module tb_add_logic_cop_branch_exec;
  reg mclk = 1'b0, resetn = 1'b0, in_valid = 1'b0, slot_p = 0, null_p = 0, ae_p = 0, cp = 0;
  reg [31:0] in_instr = 32'h0, in_pc = 32'h0, pc = 32'h1000, br_pc = 0, ae_a = 0;
  reg [3:0] cond_set = 4'h0, usable_set = 4'hf;
  reg [15:0] lf = 16'h55af;
  wire [3:0] cw, uw;
  wire wv, rv, nv, ev, es;
  wire [4:0] wr, ec;
  wire [31:0] wd, rp, ep;
  reg [31:0] gpr [0:7];
  reg [39:0] exp_q [$];
  integer mismatches = 0, total_checks = 0, i, u, k, c;
  always #5 mclk = ~mclk;
  alcb_exec #(.NCOP(4)) alcb_exec_inst (.mclk(mclk), .resetn(resetn), .in_valid(in_valid), .in_instr(in_instr),
    .in_pc(in_pc), .cop_condition_input(cw), .cop_usable(uw), .wb_valid_q(wv), .wb_reg_q(wr), .wb_data_q(wd),
    .redirect_valid_q(rv), .redirect_pc_q(rp), .slot_nullified_q(nv), .exc_valid_q(ev), .exc_code_q(ec),
    .exception_return_pc(ep), .exc_in_slot_q(es));
  alcb_cop_model alcb_cop_model_inst (.mclk(mclk), .cond_set(cond_set), .usable_set(usable_set),
    .cop_condition_input(cw), .cop_usable(uw));
  function [15:0] nx(input [15:0] v);
    nx = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task check(input [39:0] got, input [39:0] want);
    begin
      total_checks = total_checks + 1;
      if (got !== want) begin
        mismatches = mismatches + 1;
        $display("Error at %0t: saw %h expected %h", $time, got, want);
      end
    end
  endtask
  task take(input [39:0] got);
    check(got, exp_q.size() ? exp_q.pop_front() : ~got);
  endtask
  task print_verdict;
    begin
      $display("comparisons %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // reference execute: offers the word, then notes the expected pulses
  task issue(input [31:0] ins, input cv);
    reg [5:0] op;
    reg [4:0] d;
    reg [31:0] a, b, r;
    reg ovf, cbr, ok, tk, jr, bad;
    begin
      op = ins[31:26];
      a = gpr[ins[23:21]];
      b = op == 6'h00 ? gpr[ins[18:16]] : op == 6'h0c ? {16'h0, ins[15:0]} : {{16{ins[15]}}, ins[15:0]};
      r = (op == 6'h0c || op == 6'h00 && ins[5:0] == 6'h24) ? a & b : a + b;
      ovf = (op == 6'h08 || op == 6'h00 && ins[5:0] == 6'h20) && a[31] == b[31] && r[31] != a[31];
      d = op == 6'h00 ? ins[15:11] : ins[20:16];
      cbr = op[5:2] == 4'h4;
      ok = usable_set[op[1:0]];
      jr = op == 6'h00 && ins[5:1] == 5'h04;
      tk = ins[16] ? cp : !cp;
      bad = ovf && !null_p || cbr && !ok || ae_p;
      @(posedge mclk);
      #1;
      in_valid = 1'b1;
      in_instr = ins;
      in_pc = pc;
      cond_set = {4{cv}};
      if (null_p) exp_q.push_back({3'd3, 37'h0});
      else if (cbr && !ok) exp_q.push_back({3'd4, 5'h0b, pc});
      else if (cbr && tk) exp_q.push_back({3'd2, 5'h0, pc + 32'h4 + {{14{ins[15]}}, ins[15:0], 2'b00}});
      else if (jr) begin
        // the linking form writes pc + 8 before its redirect in the same cycle
        if (ins[0] && d != 5'h00) begin
          gpr[d[2:0]] = pc + 32'h8;
          exp_q.push_back({3'd1, d, pc + 32'h8});
        end
        if (a[1:0] == 2'b00) exp_q.push_back({3'd2, 5'h0, a});
      end
      else if (ovf) exp_q.push_back({2'b10, slot_p, 5'h0c, slot_p ? br_pc : pc});
      else if (!cbr && !jr && d != 5'h00) begin
        gpr[d[2:0]] = r;
        exp_q.push_back({3'd1, d, r});
      end
      if (ae_p && !ovf) exp_q.push_back({3'd4, 5'h04, ae_a});
      ae_p = jr && a[1:0] != 2'b00;
      ae_a = a;
      null_p = cbr && ok && !tk && ins[17];
      slot_p = cbr && ok || jr;
      br_pc = pc;
      cp = cv;
      pc = pc + 32'h4;
      if (bad) begin
        @(posedge mclk);
        #1;
        in_valid = 1'b0;
      end
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // every pulse takes the oldest note, in a fixed order within one cycle
  always @(negedge mclk) begin
    if (wv === 1'b1) take({3'd1, wr, wd});
    if (rv === 1'b1) take({3'd2, 5'h0, rp});
    if (nv === 1'b1) take({3'd3, 37'h0});
    if (ev === 1'b1) take({2'b10, es, ec, ep});
  end
  // hang guard, far above the roughly two hundred cycles needed
  initial begin
    #200000;
    mismatches = mismatches + 1;
    print_verdict;
  end
  initial begin
    gpr[0] = 0;
    repeat (3) @(posedge mclk);
    #1;
    resetn = 1'b1;
    for (i = 1; i < 8; i = i + 1) begin
      lf = nx(lf);
      issue({6'h09, 5'h0, i[4:0], lf}, 0);
    end
    issue({6'h09, 5'h0, 5'h2, 16'h4000}, 0);
    repeat (16) issue({6'h00, 5'h2, 5'h2, 5'h2, 5'h0, 6'h21}, 0);
    issue({6'h00, 5'h2, 5'h2, 5'h3, 5'h0, 6'h20}, 0);
    issue({6'h00, 5'h2, 5'h2, 5'h5, 5'h0, 6'h21}, 0);
    issue({6'h08, 5'h5, 5'h6, 16'hffff}, 0);
    issue({6'h09, 5'h5, 5'h6, 16'hffff}, 0);
    // random mix of the six operations, sources r0..r7, destinations may be r0
    for (i = 0; i < 60; i = i + 1) begin
      lf = nx(lf);
      k = lf[15:13] % 6;
      if (k < 3) issue({6'h00, 2'b0, lf[2:0], 2'b0, lf[5:3], 2'b0, lf[8:6], 5'h0, k == 2 ? 6'h24 : 6'h20 + k[5:0]}, 0);
      else issue({k == 3 ? 6'h08 : k == 4 ? 6'h09 : 6'h0c, 2'b0, lf[2:0], 2'b0, lf[5:3], nx(lf)}, 0);
    end
    $display("test arithmetic done");
    // slots are always plain adds and nothing links through r31
    for (u = 0; u < 4; u = u + 1) for (k = 0; k < 3; k = k + 1) for (c = 0; c < 2; c = c + 1) begin
      usable_set = (u == 3 && c == 1) ? 4'h7 : 4'hf;
      lf = nx(lf);
      issue({6'h09, 5'h7, 5'h7, 16'h0001}, c[0]);
      issue({4'h4, u[1:0], 5'h08, k[4:0], lf}, !c[0]);
      issue({6'h09, 5'h7, 5'h7, 16'h0001}, !c[0]);
    end
    $display("test coprocessor branches done");
    issue({6'h09, 5'h0, 5'h4, 16'h2001}, 0);
    issue({6'h00, 5'h4, 10'h0, 5'h0, 6'h08}, 0);
    issue({6'h09, 5'h1, 5'h1, 16'h0001}, 0);
    issue({6'h09, 5'h0, 5'h4, 16'h2000}, 0);
    issue({6'h00, 5'h4, 10'h0, 5'h0, 6'h08}, 0);
    issue({6'h00, 5'h2, 5'h2, 5'h3, 5'h0, 6'h20}, 0);
    // linking register jump; its slot reads the fresh link through the bypass
    issue({6'h00, 5'h4, 5'h0, 5'h6, 5'h0, 6'h09}, 0);
    issue({6'h09, 5'h6, 5'h6, 16'h0001}, 0);
    @(posedge mclk);
    #1;
    in_valid = 1'b0;
    repeat (5) @(posedge mclk);
    check(40'(exp_q.size()), 40'h0);
    $display("test register jumps done");
    print_verdict;
  end
endmodule

// *** hw/alcb_exec.v ***
// alcb_exec.v: decode and execute of adds, ands, register jumps and
// coprocessor-condition branches, with delay-slot and restart handling.
// assumes in-order issue of one instruction per cycle on mclk, fetch that
// follows redirect_valid and exc_valid, and condition / usable bits driven
// from logic on mclk.
//
// How it works
// - every jump and branch takes effect after one delay-slot instruction
// - a fault in the delay slot reports the branch address for restart
// - register jump target with low bits nonzero raises address error
// - signed register add writes rd, traps on overflow leaving rd alone
// - signed immediate add writes rt, traps on overflow leaving rt alone
// - unsigned immediate add sign-extends immediate and never traps
// - unsigned register add writes rd and never traps
// - register and writes bitwise and of rs and rt into rd
// - immediate and zero-extends immediate, ands with rs into rt
// - coprocessor branch target is slot address plus shifted offset
// - branch condition is the one sampled during the previous instruction
// - false branch is taken when the condition is false
// - false-likely branch annuls the delay slot when condition is true
// - true branch is taken when the condition is true
// - opcode bits pick the coprocessor; unusable unit raises an exception
// - register zero reads zero and ignores writes
`timescale 1ns/1ps
`include "alcb_regs.vh"

module alcb_exec #(
  parameter NCOP = 4
) (
  input wire mclk, // core clock, 100 MHz
  input wire resetn, // synchronous reset, active low
  input wire in_valid, // instruction offered this cycle
  input wire [31:0] in_instr, // instruction word
  input wire [31:0] in_pc, // address of the instruction
  input wire [NCOP-1:0] cop_condition_input, // one condition bit per unit
  input wire [NCOP-1:0] cop_usable, // unit usable flags
  output reg wb_valid_q, // a register was written
  output reg [4:0] wb_reg_q, // register written
  output reg [31:0] wb_data_q, // value written
  output reg redirect_valid_q, // fetch must continue at redirect_pc_q
  output reg [31:0] redirect_pc_q, // jump or branch target
  output reg slot_nullified_q, // delay-slot instruction was annulled
  output reg exc_valid_q, // exception raised
  output reg [4:0] exc_code_q, // exception cause
  output reg [31:0] exception_return_pc, // restart address
  output reg exc_in_slot_q // exception hit a delay-slot instruction
);

  // slot tracker states
  localparam ST_RUN = 2'b01;
  localparam ST_SLOT = 2'b10;

  ////////////////////////////////////////////////////////////////////////////
  // execute-stage registers
  reg ex_valid_q;
  reg [31:0] ex_instr_q;
  reg [31:0] ex_pc_q;
  reg [NCOP-1:0] cond_q;
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg slot_null_q;
  reg slot_null_d;
  reg [31:0] slot_bpc_q;
  reg [31:0] slot_bpc_d;
  reg slot_adel_q;
  reg slot_adel_d;
  reg [31:0] slot_tgt_q;
  reg [31:0] slot_tgt_d;
  wire [31:0] rs_val;
  wire [31:0] rt_val;

  // decoded fields
  wire [5:0] op = ex_instr_q[31:26];
  wire [4:0] f_rs = ex_instr_q[25:21];
  wire [4:0] f_rt = ex_instr_q[20:16];
  wire [4:0] f_rd = ex_instr_q[15:11];
  wire [4:0] f_sa = ex_instr_q[10:6];
  wire [5:0] f_fn = ex_instr_q[5:0];
  wire [15:0] imm = ex_instr_q[15:0];
  wire [31:0] imm_sext = {{16{imm[15]}}, imm};
  wire [31:0] imm_zext = {16'h0000, imm};
  wire [31:0] br_off = {{14{imm[15]}}, imm, 2'b00};
  wire [31:0] slot_pc = ex_pc_q + `ALCB_INSN_BYTES;
  wire [1:0] cop_sel = op[1:0];

  // adders; overflow is a carry-out mismatch of bits 31 and 30
  wire [31:0] sum_reg = rs_val + rt_val;
  wire [31:0] sum_imm = rs_val + imm_sext;
  wire ovf_reg = (rs_val[31] == rt_val[31]) && (sum_reg[31] != rs_val[31]);
  wire ovf_imm = (rs_val[31] == imm_sext[31]) && (sum_imm[31] != rs_val[31]);

  wire is_spec = (op == `ALCB_OP_SPECIAL);
  wire spec_alu = is_spec && (f_sa == `ALCB_SHIFT_ZERO);
  wire is_jr = is_spec && (f_fn == `ALCB_FN_JUMP_REG);
  wire is_jalr = is_spec && (f_fn == `ALCB_FN_JUMP_LINK_REG);
  wire is_cop = (op[5:2] == `ALCB_OP_COP_TOP) && (f_rs == `ALCB_COP_BC);
  wire cop_f = is_cop && (f_rt == `ALCB_COP_FALSE);
  wire cop_fl = is_cop && (f_rt == `ALCB_COP_FALSE_LIKELY);
  wire cop_t = is_cop && (f_rt == `ALCB_COP_TRUE);
  wire cop_br = cop_f || cop_fl || cop_t;
  wire cop_cond = cond_q[cop_sel];
  wire in_slot = (state_q == ST_SLOT);

  ////////////////////////////////////////////////////////////////////////////
  // combinational execute
  reg we_d;
  reg [4:0] wa_d;
  reg [31:0] wd_d;
  reg exc_d;
  reg [4:0] code_d;
  reg [31:0] epc_d;
  reg exc_slot_d;
  reg redir_d;
  reg [31:0] redir_pc_d;
  reg null_d;
  reg br_d;
  reg br_likely_d;
  reg br_take_d;

  always @* begin
    we_d = 1'b0;
    wa_d = `ALCB_RST_REG;
    wd_d = `ALCB_RST_WORD;
    exc_d = 1'b0;
    code_d = `ALCB_RST_REG;
    epc_d = ex_pc_q;
    exc_slot_d = 1'b0;
    redir_d = 1'b0;
    redir_pc_d = `ALCB_RST_WORD;
    null_d = 1'b0;
    br_d = 1'b0;
    br_likely_d = 1'b0;
    br_take_d = 1'b0;
    if (ex_valid_q && in_slot && slot_null_q) begin
      null_d = 1'b1;
    end else if (ex_valid_q) begin
      if (spec_alu && f_fn == `ALCB_FN_ADD) begin
        if (ovf_reg) begin
          exc_d = 1'b1;
          code_d = `ALCB_EXC_OVERFLOW;
        end else begin
          we_d = 1'b1;
          wa_d = f_rd;
          wd_d = sum_reg;
        end
      end else if (spec_alu && f_fn == `ALCB_FN_ADD_NT) begin
        we_d = 1'b1;
        wa_d = f_rd;
        wd_d = sum_reg;
      end else if (spec_alu && f_fn == `ALCB_FN_AND) begin
        we_d = 1'b1;
        wa_d = f_rd;
        wd_d = rs_val & rt_val;
      end else if (op == `ALCB_OP_ADD_IMM) begin
        if (ovf_imm) begin
          exc_d = 1'b1;
          code_d = `ALCB_EXC_OVERFLOW;
        end else begin
          we_d = 1'b1;
          wa_d = f_rt;
          wd_d = sum_imm;
        end
      end else if (op == `ALCB_OP_ADD_IMM_NT) begin
        we_d = 1'b1;
        wa_d = f_rt;
        wd_d = sum_imm;
      end else if (op == `ALCB_OP_AND_IMM) begin
        we_d = 1'b1;
        wa_d = f_rt;
        wd_d = rs_val & imm_zext;
      end else if (is_jr || is_jalr) begin
        // target alignment is checked here; a misaligned target gets no redirect and faults after the slot
        br_d = 1'b1;
        br_take_d = 1'b1;
        redir_d = (rs_val[1:0] == 2'b00);
        redir_pc_d = rs_val;
        if (is_jalr) begin
          we_d = 1'b1; // link written after rs was read, so restart stays safe
          wa_d = f_rd;
          wd_d = ex_pc_q + `ALCB_LINK_BYTES;
        end
      end else if (cop_br) begin
        if (!cop_usable[cop_sel]) begin
          exc_d = 1'b1;
          code_d = `ALCB_EXC_COP_UNUSABLE;
        end else begin
          br_d = 1'b1;
          br_likely_d = cop_fl;
          br_take_d = cop_t ? cop_cond : !cop_cond;
          redir_d = br_take_d;
          redir_pc_d = slot_pc + br_off;
        end
      end
      // a faulting slot instruction restarts at its branch
      if (exc_d && in_slot) begin
        epc_d = slot_bpc_q;
        exc_slot_d = 1'b1;
      end
    end
    // misaligned register jump target faults once the slot is done
    if (ex_valid_q && in_slot && slot_adel_q && !exc_d) begin
      exc_d = 1'b1;
      code_d = `ALCB_EXC_ADDR_ERR;
      epc_d = slot_tgt_q;
      exc_slot_d = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // slot tracker; a branch seen in a slot simply restarts tracking
  always @* begin
    state_d = state_q;
    slot_null_d = slot_null_q;
    slot_bpc_d = slot_bpc_q;
    slot_adel_d = slot_adel_q;
    slot_tgt_d = slot_tgt_q;
    case (state_q)
      ST_RUN: begin
        if (br_d && !exc_d) begin
          state_d = ST_SLOT;
          slot_null_d = br_likely_d && !br_take_d;
          slot_bpc_d = ex_pc_q;
          slot_adel_d = (is_jr || is_jalr) && (rs_val[1:0] != 2'b00);
          slot_tgt_d = rs_val;
        end
      end
      ST_SLOT: begin
        if (ex_valid_q) begin
          state_d = (br_d && !exc_d) ? ST_SLOT : ST_RUN;
          slot_null_d = br_likely_d && !br_take_d;
          slot_bpc_d = ex_pc_q;
          slot_adel_d = br_d && (is_jr || is_jalr) && (rs_val[1:0] != 2'b00);
          slot_tgt_d = rs_val;
        end
      end
      default: begin
        state_d = ST_RUN;
        slot_null_d = 1'b0;
        slot_adel_d = 1'b0;
      end
    endcase
    if (exc_d) begin
      state_d = ST_RUN;
      slot_adel_d = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // issue register; the instruction offered during an exception is dropped
  always @(posedge mclk) begin
    if (!resetn) begin
      ex_valid_q <= 1'b0;
      ex_instr_q <= `ALCB_RST_WORD;
      ex_pc_q <= `ALCB_RST_WORD;
      cond_q <= {NCOP{1'b0}};
      state_q <= ST_RUN;
      slot_null_q <= 1'b0;
      slot_bpc_q <= `ALCB_RST_WORD;
      slot_adel_q <= 1'b0;
      slot_tgt_q <= `ALCB_RST_WORD;
    end else begin
      ex_valid_q <= in_valid && !exc_d;
      ex_instr_q <= in_instr;
      ex_pc_q <= in_pc;
      if (ex_valid_q) begin
        cond_q <= cop_condition_input;
      end
      state_q <= state_d;
      slot_null_q <= slot_null_d;
      slot_bpc_q <= slot_bpc_d;
      slot_adel_q <= slot_adel_d;
      slot_tgt_q <= slot_tgt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs
  always @(posedge mclk) begin
    if (!resetn) begin
      wb_valid_q <= 1'b0;
      wb_reg_q <= `ALCB_RST_REG;
      wb_data_q <= `ALCB_RST_WORD;
      redirect_valid_q <= 1'b0;
      redirect_pc_q <= `ALCB_RST_WORD;
      slot_nullified_q <= 1'b0;
      exc_valid_q <= 1'b0;
      exc_code_q <= `ALCB_RST_REG;
      exception_return_pc <= `ALCB_RST_WORD;
      exc_in_slot_q <= 1'b0;
    end else begin
      wb_valid_q <= we_d && (wa_d != `ALCB_REG_ZERO);
      wb_reg_q <= wa_d;
      wb_data_q <= wd_d;
      redirect_valid_q <= redir_d && !exc_d;
      redirect_pc_q <= redir_pc_d;
      slot_nullified_q <= null_d;
      exc_valid_q <= exc_d;
      exc_code_q <= code_d;
      if (exc_d) begin
        exception_return_pc <= epc_d;
      end
      exc_in_slot_q <= exc_slot_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register file read at issue, written from the execute stage
  alcb_regfile #(
    .WIDTH(32),
    .DEPTH(32),
    .AW(5)
  ) u_regfile (
    .mclk(mclk),
    .resetn(resetn),
    .ra_addr(in_instr[25:21]),
    .rb_addr(in_instr[20:16]),
    .ra_data_q(rs_val),
    .rb_data_q(rt_val),
    .wr_en(we_d),
    .wr_addr(wa_d),
    .wr_data(wd_d)
  );

endmodule

// *** hw/alcb_regfile.v ***
// alcb_regfile.v: general register file, two registered read ports, one write port.
// assumes the write port is driven from logic on mclk; register zero is never stored.
`timescale 1ns/1ps
`include "alcb_regs.vh"

module alcb_regfile #(
  parameter WIDTH = 32,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  input wire mclk, // core clock
  input wire resetn, // synchronous reset, active low
  input wire [AW-1:0] ra_addr, // read port a address
  input wire [AW-1:0] rb_addr, // read port b address
  output reg [WIDTH-1:0] ra_data_q, // read port a data, one cycle later
  output reg [WIDTH-1:0] rb_data_q, // read port b data, one cycle later
  input wire wr_en, // write strobe
  input wire [AW-1:0] wr_addr, // write address
  input wire [WIDTH-1:0] wr_data // write data
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];

  ////////////////////////////////////////////////////////////////////////////
  // write port; register zero is never written so it keeps reading zero
  always @(posedge mclk) begin
    if (wr_en && wr_addr != `ALCB_REG_ZERO) begin
      mem[wr_addr] <= wr_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read ports bypass a same-cycle write, so back to back users need no stall
  always @(posedge mclk) begin
    if (!resetn) begin
      ra_data_q <= {WIDTH{1'b0}};
      rb_data_q <= {WIDTH{1'b0}};
    end else begin
      if (ra_addr == `ALCB_REG_ZERO) begin
        ra_data_q <= {WIDTH{1'b0}};
      end else if (wr_en && wr_addr == ra_addr) begin
        ra_data_q <= wr_data;
      end else begin
        ra_data_q <= mem[ra_addr];
      end
      if (rb_addr == `ALCB_REG_ZERO) begin
        rb_data_q <= {WIDTH{1'b0}};
      end else if (wr_en && wr_addr == rb_addr) begin
        rb_data_q <= wr_data;
      end else begin
        rb_data_q <= mem[rb_addr];
      end
    end
  end

endmodule

// *** hw/alcb_regs.vh ***
// alcb_regs.vh: opcode fields, exception codes and reset values of the
// add / and / coprocessor-branch execute unit.
// assumes inclusion by bare name from the design files under hw/.
`ifndef ALCB_REGS_VH
`define ALCB_REGS_VH

// major opcodes
`define ALCB_OP_SPECIAL 6'h00
`define ALCB_OP_ADD_IMM 6'h08
`define ALCB_OP_ADD_IMM_NT 6'h09
`define ALCB_OP_AND_IMM 6'h0c
`define ALCB_OP_COP_TOP 4'h4

// function codes under the special opcode
`define ALCB_FN_ADD 6'h20
`define ALCB_FN_ADD_NT 6'h21
`define ALCB_FN_AND 6'h24
`define ALCB_FN_JUMP_REG 6'h08
`define ALCB_FN_JUMP_LINK_REG 6'h09

// coprocessor branch sub-fields (bits 25..21 and 20..16)
`define ALCB_COP_BC 5'h08
`define ALCB_COP_FALSE 5'h00
`define ALCB_COP_TRUE 5'h01
`define ALCB_COP_FALSE_LIKELY 5'h02

// exception codes reported on exc_code
`define ALCB_EXC_ADDR_ERR 5'h04
`define ALCB_EXC_COP_UNUSABLE 5'h0b
`define ALCB_EXC_OVERFLOW 5'h0c

// fixed numbers of the datapath
`define ALCB_SHIFT_ZERO 5'h00
`define ALCB_REG_ZERO 5'h00
`define ALCB_INSN_BYTES 32'h0000_0004
`define ALCB_LINK_BYTES 32'h0000_0008
`define ALCB_RST_WORD 32'h0000_0000
`define ALCB_RST_REG 5'h00

`endif
